// ===== verilog/ultrasonic_burst_sequencer.sv
// Functional notes
// - stop charging once supply reaches target
// - target level and charge current from fields
// - regulation off at reset; software clears
// - listen disable stops charging after burst
// - recharge request restarts stopped charging
// - status shows supply ready flag
// - recharge still set keeps charging after burst
// - regulation off ignores listen and recharge
// - mode field selects burst excitation mode
// - enable first, start on next falling edge
// - mode 0 enabled by command trigger bit
// - modes 0/1 count second pin fall intervals
// - mode 0 ends on count or trigger cleared
// - mode 0 rearms on trigger low then high
// - outputs follow both pins after start
// - mode 1 enabled by first pin falling
// - mode 1 rearms on first pin low-high-low
// - mode 2 enable either fall, start first
// - mode 2 overlap ends burst and disables
// - mode 2 ignores pulse count
// - zero count bursts until end signalled
//
// The address map and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/100ps
`include "burst_regs.svh"
module ultrasonic_burst_sequencer #(
   parameter int OVERLAP_CYCLES = `OVERLAP_CYCLES
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic first_control_pin,
   input wire logic second_control_pin,
   input wire logic supply_at_level,
   output logic driver_output_a,
   output logic driver_output_b,
   output logic supply_charge_enable,
   output logic [3:0] supply_target_level,
   output logic [3:0] supply_charge_current
);
   localparam logic [7:0] OVL_LIMIT = 8'(OVERLAP_CYCLES);

   burst_pkg::seq_state_t st_r;
   burst_pkg::seq_state_t st_nxt;

   logic p1_lvl;
   logic p1_rise;
   logic p1_fall;
   logic p2_lvl;
   logic p2_fall;
   logic lvl_ok;

   // ==========================================
   // pin synchronisers
   pin_sync_edge u_sync_p1 (
      .mclk(mclk),
      .rst(rst),
      .din(first_control_pin),
      .level(p1_lvl),
      .rise(p1_rise),
      .fall(p1_fall)
   );

   pin_sync_edge u_sync_p2 (
      .mclk(mclk),
      .rst(rst),
      .din(second_control_pin),
      .level(p2_lvl),
      .rise(),
      .fall(p2_fall)
   );

   pin_sync_edge u_sync_lvl (
      .mclk(mclk),
      .rst(rst),
      .din(supply_at_level),
      .level(lvl_ok),
      .rise(),
      .fall()
   );

   // ==========================================
   // register read decode
   function automatic logic [31:0] reg_read(
      input logic [7:0] addr,
      input burst_pkg::seq_state_t s,
      input logic ok
   );
      logic [31:0] d;
      d = 32'h0000_0000;
      unique case (addr)
         `ADDR_SUPPLY_CTRL: begin
            d[`SUP_TARGET_LSB +: 4] = s.tgt;
            d[`SUP_CURRENT_LSB +: 4] = s.cur;
            d[`SUP_REG_OFF_BIT] = s.hi_z;
            d[`SUP_LISTEN_DIS_BIT] = s.lst_dis;
            d[`SUP_RECHARGE_BIT] = s.rech;
         end
         `ADDR_DEV_CTRL_THIRD: begin
            d[`MODE_LSB +: 2] = s.mode;
         end
         `ADDR_FLIGHT_CONFIG: begin
            d[`TOF_CMD_BIT] = s.cmd;
         end
         `ADDR_BURST_PULSE: begin
            d[`PULSE_LSB +: 8] = s.pulses;
         end
         `ADDR_DEVICE_STATUS: begin
            d[`STAT_READY_BIT] = ~s.hi_z & ok;
            d[`STAT_CHARGE_BIT] = s.chg;
            d[`STAT_ENABLED_BIT] = (s.bst == burst_pkg::BST_ENABLED);
            d[`STAT_ACTIVE_BIT] = (s.bst == burst_pkg::BST_ACTIVE);
            d[`STAT_LISTEN_STOP_BIT] = s.lst_stop;
         end
         default: begin
            d = 32'h0000_0000;
         end
      endcase
      return d;
   endfunction

   // ==========================================
   // next-state logic
   always_comb begin
      logic req;
      logic wr_lo;
      logic wr_hi;
      logic cmd_rise;
      logic rech_rise;
      logic in_burst;
      logic ovl_hit;
      logic done;
      logic last;
      req = 1'b0;
      wr_lo = 1'b0;
      wr_hi = 1'b0;
      cmd_rise = 1'b0;
      rech_rise = 1'b0;
      in_burst = 1'b0;
      ovl_hit = 1'b0;
      done = 1'b0;
      last = 1'b0;
      st_nxt = st_r;

      // bus slave: take a request while waitrequest is high, answer next cycle
      req = (avs_read | avs_write) & st_r.waitreq;
      st_nxt.waitreq = ~req;
      if (req && avs_read) begin
         st_nxt.rdata = reg_read(avs_address, st_r, lvl_ok);
      end
      wr_lo = req & avs_write & avs_byteenable[0];
      wr_hi = req & avs_write & avs_byteenable[1];
      if (wr_lo) begin
         unique case (avs_address)
            `ADDR_SUPPLY_CTRL: begin
               st_nxt.tgt = avs_writedata[`SUP_TARGET_LSB +: 4];
               st_nxt.cur = avs_writedata[`SUP_CURRENT_LSB +: 4];
            end
            `ADDR_DEV_CTRL_THIRD: begin
               st_nxt.mode = avs_writedata[`MODE_LSB +: 2];
            end
            `ADDR_FLIGHT_CONFIG: begin
               st_nxt.cmd = avs_writedata[`TOF_CMD_BIT];
            end
            `ADDR_BURST_PULSE: begin
               st_nxt.pulses = avs_writedata[`PULSE_LSB +: 8];
            end
            default: begin
               st_nxt.cmd = st_r.cmd;
            end
         endcase
      end
      if (wr_hi && avs_address == `ADDR_SUPPLY_CTRL) begin
         st_nxt.hi_z = avs_writedata[`SUP_REG_OFF_BIT];
         st_nxt.lst_dis = avs_writedata[`SUP_LISTEN_DIS_BIT];
         st_nxt.rech = avs_writedata[`SUP_RECHARGE_BIT];
      end

      // trigger bit histories for edge detection
      st_nxt.cmd_prev = st_r.cmd;
      st_nxt.rech_prev = st_r.rech;
      cmd_rise = st_r.cmd & ~st_r.cmd_prev;
      rech_rise = st_r.rech & ~st_r.rech_prev;

      // mode 2 overlap timer, both pins high during a burst
      in_burst = (st_r.bst != burst_pkg::BST_IDLE);
      if (st_r.mode == 2'd2 && in_burst && p1_lvl && p2_lvl) begin
         st_nxt.ovl = st_r.ovl + 8'h01;
      end else begin
         st_nxt.ovl = 8'h00;
      end
      ovl_hit = (st_r.mode == 2'd2) && in_burst && p1_lvl && p2_lvl &&
                (st_r.ovl + 8'h01 >= OVL_LIMIT);

      // last counted interval; zero count never ends on its own
      last = p2_fall && (st_r.pulses != 8'h00) &&
             (st_r.cnt + 8'h01 == st_r.pulses);

      // burst sequencer
      unique case (st_r.bst)
         burst_pkg::BST_IDLE: begin
            st_nxt.cnt = 8'h00;
            unique case (st_r.mode)
               2'd0: begin
                  if (cmd_rise) begin
                     st_nxt.bst = burst_pkg::BST_ENABLED;
                  end
               end
               2'd1: begin
                  if (p1_fall) begin
                     st_nxt.bst = burst_pkg::BST_ENABLED;
                  end
               end
               2'd2: begin
                  if (p1_fall || p2_fall) begin
                     st_nxt.bst = burst_pkg::BST_ENABLED;
                  end
               end
               default: begin
                  st_nxt.bst = burst_pkg::BST_IDLE;
               end
            endcase
         end
         burst_pkg::BST_ENABLED: begin
            st_nxt.cnt = 8'h00;
            unique case (st_r.mode)
               2'd0: begin
                  if (!st_r.cmd) begin
                     st_nxt.bst = burst_pkg::BST_IDLE;
                  end else if (p2_fall) begin
                     st_nxt.bst = burst_pkg::BST_ACTIVE;
                  end
               end
               2'd1: begin
                  if (p1_rise) begin
                     st_nxt.bst = burst_pkg::BST_IDLE;
                  end else if (p2_fall) begin
                     st_nxt.bst = burst_pkg::BST_ACTIVE;
                  end
               end
               2'd2: begin
                  if (ovl_hit) begin
                     st_nxt.bst = burst_pkg::BST_IDLE;
                  end else if (p1_fall) begin
                     st_nxt.bst = burst_pkg::BST_ACTIVE;
                  end
               end
               default: begin
                  st_nxt.bst = burst_pkg::BST_IDLE;
               end
            endcase
         end
         burst_pkg::BST_ACTIVE: begin
            if (p2_fall) begin
               st_nxt.cnt = st_r.cnt + 8'h01;
            end
            unique case (st_r.mode)
               2'd0: begin
                  done = !st_r.cmd || last;
               end
               2'd1: begin
                  done = p1_rise || last;
               end
               2'd2: begin
                  done = ovl_hit;
               end
               default: begin
                  done = 1'b1;
               end
            endcase
            if (done) begin
               st_nxt.bst = burst_pkg::BST_IDLE;
            end
         end
      endcase

      // drivers follow the synchronised pins only while active
      if (st_nxt.bst == burst_pkg::BST_ACTIVE) begin
         st_nxt.out_a = p1_lvl & ~p2_lvl;
         st_nxt.out_b = p2_lvl & ~p1_lvl;
      end else begin
         st_nxt.out_a = 1'b0;
         st_nxt.out_b = 1'b0;
      end

      // listen-mode charge stop; a same-cycle recharge wins, since recharge high blocks the set
      if (st_r.hi_z) begin
         st_nxt.lst_stop = 1'b0;
      end else if (done && st_r.lst_dis && !st_r.rech) begin
         st_nxt.lst_stop = 1'b1;
      end else if (rech_rise) begin
         st_nxt.lst_stop = 1'b0;
      end

      // charge current on until the monitor sees the target level
      st_nxt.chg = ~st_r.hi_z & ~st_nxt.lst_stop & ~lvl_ok;
   end

   // ==========================================
   // state register
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_r <= '{
            waitreq: 1'b1,
            rdata: 32'h0000_0000,
            tgt: 4'h0,
            cur: 4'h0,
            hi_z: 1'b1,
            lst_dis: 1'b0,
            rech: 1'b0,
            rech_prev: 1'b0,
            mode: 2'h0,
            cmd: 1'b0,
            cmd_prev: 1'b0,
            pulses: 8'h00,
            cnt: 8'h00,
            ovl: 8'h00,
            bst: burst_pkg::BST_IDLE,
            lst_stop: 1'b0,
            chg: 1'b0,
            out_a: 1'b0,
            out_b: 1'b0
         };
      end else begin
         st_r <= st_nxt;
      end
   end

   // ==========================================
   // outputs, all from the state register
   assign avs_readdata = st_r.rdata;
   assign avs_waitrequest = st_r.waitreq;
   assign driver_output_a = st_r.out_a;
   assign driver_output_b = st_r.out_b;
   assign supply_charge_enable = st_r.chg;
   assign supply_target_level = st_r.tgt;
   assign supply_charge_current = st_r.cur;
endmodule

// ===== common/burst_regs.svh
`ifndef BURST_REGS_SVH
`define BURST_REGS_SVH
// ==========================================
// register byte offsets
`define ADDR_SUPPLY_CTRL 8'h00
`define ADDR_DEV_CTRL_THIRD 8'h04
`define ADDR_FLIGHT_CONFIG 8'h08
`define ADDR_BURST_PULSE 8'h0C
`define ADDR_DEVICE_STATUS 8'h10
// ==========================================
// supply control fields
`define SUP_TARGET_LSB 0
`define SUP_CURRENT_LSB 4
`define SUP_REG_OFF_BIT 8
`define SUP_LISTEN_DIS_BIT 9
`define SUP_RECHARGE_BIT 10
`define SUP_CTRL_RESET 32'h0000_0100
// ==========================================
// control, config and status fields
`define MODE_LSB 0
`define TOF_CMD_BIT 0
`define PULSE_LSB 0
`define STAT_READY_BIT 0
`define STAT_CHARGE_BIT 1
`define STAT_ENABLED_BIT 2
`define STAT_ACTIVE_BIT 3
`define STAT_LISTEN_STOP_BIT 4
// ==========================================
// timing
`define MCLK_PERIOD_NS 5
`define OVERLAP_LIMIT_NS 50
`define OVERLAP_CYCLES ((`OVERLAP_LIMIT_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`endif

// ===== common/burst_pkg.sv
package burst_pkg;
   // ==========================================
   // sequencer states
   typedef enum logic [1:0] {
      BST_IDLE,
      BST_ENABLED,
      BST_ACTIVE
   } burst_state_t;

   // ==========================================
   // synchroniser state
   typedef struct packed {
      logic meta;
      logic sync;
      logic prev;
   } sync_state_t;

   // ==========================================
   // whole sequencer state
   typedef struct packed {
      logic waitreq;
      logic [31:0] rdata;
      logic [3:0] tgt;
      logic [3:0] cur;
      logic hi_z;
      logic lst_dis;
      logic rech;
      logic rech_prev;
      logic [1:0] mode;
      logic cmd;
      logic cmd_prev;
      logic [7:0] pulses;
      logic [7:0] cnt;
      logic [7:0] ovl;
      burst_state_t bst;
      logic lst_stop;
      logic chg;
      logic out_a;
      logic out_b;
   } seq_state_t;
endpackage

// ===== verilog/pin_sync_edge.sv
`timescale 1ns/100ps
module pin_sync_edge (
   input wire logic mclk,
   input wire logic rst,
   input wire logic din,
   output logic level,
   output logic rise,
   output logic fall
);
   burst_pkg::sync_state_t st_r;
   burst_pkg::sync_state_t st_nxt;

   // ==========================================
   // two-stage synchroniser and edge history
   always_comb begin
      st_nxt = st_r;
      st_nxt.meta = din;
      st_nxt.sync = st_r.meta;
      st_nxt.prev = st_r.sync;
   end

   // pins idle high (pull-ups), so reset to high avoids a false fall
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_r <= 3'b111;
      end else begin
         st_r <= st_nxt;
      end
   end

   // edges look only at the second stage and its history
   assign level = st_r.sync;
   assign rise = st_r.sync & ~st_r.prev;
   assign fall = ~st_r.sync & st_r.prev;
endmodule

// ===== test/burst_checker.sv
`timescale 1ns/100ps
// ==========================================
// port checks of the burst sequencer
module burst_checker #(
   parameter int OVERLAP_CYCLES = 10
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic first_control_pin,
   input wire logic second_control_pin,
   input wire logic supply_at_level,
   input wire logic driver_output_a,
   input wire logic driver_output_b,
   input wire logic supply_charge_enable,
   input wire logic [3:0] supply_target_level,
   input wire logic [3:0] supply_charge_current
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);

   // bus handshake
   property p_answer;
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
   endproperty
   a_answer: assert property (p_answer) else $error("bus answer late");
   property p_low_once;
      !avs_waitrequest |=> avs_waitrequest;
   endproperty
   a_low_once: assert property (p_low_once) else $error("wait low too long");
   property p_cause;
      $fell(avs_waitrequest) |-> $past(avs_read || avs_write);
   endproperty
   a_cause: assert property (p_cause) else $error("answer without request");
   property p_unmapped;
      avs_read && avs_waitrequest && avs_address > 8'h10 |=> avs_readdata == 32'h0000_0000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

   // supply level fields and charge cut-off
   property p_levels;
      avs_write && avs_waitrequest && avs_address == 8'h00 && avs_byteenable[0] |->
         ##2 {supply_charge_current, supply_target_level} == $past(avs_writedata[7:0], 2);
   endproperty
   a_levels: assert property (p_levels) else $error("level fields wrong");
   property p_cutoff;
      supply_at_level [*4] |-> !supply_charge_enable;
   endproperty
   a_cutoff: assert property (p_cutoff) else $error("charging above target");

   // driver outputs follow the pins
   property p_excl;
      !(driver_output_a && driver_output_b);
   endproperty
   a_excl: assert property (p_excl) else $error("both drivers on");
   property p_a_first;
      !first_control_pin [*5] |-> !driver_output_a;
   endproperty
   a_a_first: assert property (p_a_first) else $error("output a without pin");
   property p_a_second;
      second_control_pin [*5] |-> !driver_output_a;
   endproperty
   a_a_second: assert property (p_a_second) else $error("output a with pin high");
   property p_b_second;
      !second_control_pin [*5] |-> !driver_output_b;
   endproperty
   a_b_second: assert property (p_b_second) else $error("output b without pin");
endmodule

bind ultrasonic_burst_sequencer burst_checker #(.OVERLAP_CYCLES(OVERLAP_CYCLES)) chk (
   .mclk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
   .avs_readdata, .avs_waitrequest, .first_control_pin, .second_control_pin,
   .supply_at_level, .driver_output_a, .driver_output_b, .supply_charge_enable,
   .supply_target_level, .supply_charge_current
);

// ===== test/pin_master.sv
`timescale 1ns/100ps
// ==========================================
// host side of the two control pins
module pin_master (
   input wire logic run,
   input wire logic two_phase,
   input wire logic hold_first,
   output logic first_control_pin,
   output logic second_control_pin
);
   logic p1 = 1'b1;
   // first pin is a host level except in two-phase drive
   assign first_control_pin = two_phase ? p1 : hold_first;
   // burst clock, stands high between frames
   initial begin
      second_control_pin = 1'b1;
      forever begin
         wait (run);
         #13;
         while (run) begin
            if (two_phase) begin
               p1 = 1'b0;
               #5 second_control_pin = 1'b1;
               #35 second_control_pin = 1'b0;
               #5 p1 = 1'b1;
               #35;
            end else begin
               #40 second_control_pin = 1'b0;
               #40 second_control_pin = 1'b1;
            end
         end
         second_control_pin = 1'b1;
      end
   end
endmodule

// ===== test/ultrasonic_burst_sequencer_test.sv
`timescale 1ns/100ps
`include "burst_regs.svh"
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin fails++; \
   $display("unexpected %s expected %0h seen %0h", nm, ex, got); end end
module ultrasonic_burst_sequencer_test;
   logic mclk;
   logic rst = 1'b1;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
   logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, v;
   logic run = 1'b0, two_phase = 1'b0, hold_first = 1'b1, supply_at_level = 1'b0;
   logic first_control_pin, second_control_pin, driver_output_a, driver_output_b;
   logic supply_charge_enable, ab_r = 1'b0;
   logic [3:0] supply_target_level, supply_charge_current;
   int fails = 0, n_checks = 0, pulses = 0;

   ultrasonic_burst_sequencer #(.OVERLAP_CYCLES(2)) uut (
      .mclk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .first_control_pin,
      .second_control_pin, .supply_at_level, .driver_output_a, .driver_output_b,
      .supply_charge_enable, .supply_target_level, .supply_charge_current
   );
   pin_master pm (.run, .two_phase, .hold_first, .first_control_pin, .second_control_pin);

   // clock
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   // count rising edges of either driver output
   always @(posedge mclk) begin
      ab_r <= driver_output_a | driver_output_b;
      if ((driver_output_a | driver_output_b) && !ab_r)
         pulses++;
   end

   // one register access, held until waitrequest is seen low
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int t;
      t = 0;
      @(posedge mclk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      @(posedge mclk);
      while (avs_waitrequest !== 1'b0 && t < 50) begin
         t++;
         @(posedge mclk);
      end
      if (t == 50) fails++;
      v = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask

   // run the pin clock; kind 1 ends by first pin, kind 2 by clearing the command
   task automatic burst(input int cyc, input int kind);
      @(posedge mclk);
      pulses = 0;
      run <= 1'b1;
      if (kind == 1) hold_first <= 1'b0;
      repeat (cyc) @(posedge mclk);
      if (kind == 1) hold_first <= 1'b1;
      if (kind == 2) bus(1'b1, `ADDR_FLIGHT_CONFIG, 32'h0000_0000);
      repeat (80) @(posedge mclk);
      run <= 1'b0;
      repeat (60) @(posedge mclk);
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // watchdog
   initial begin
      #100us;
      fails++;
      close_out();
   end

   // test sequence
   initial begin
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      bus(1'b0, `ADDR_SUPPLY_CTRL, 32'h0000_0000);
      `CHK("supply_ctrl", `SUP_CTRL_RESET, v)
      `CHK("charge", 1'b0, supply_charge_enable)
      bus(1'b0, 8'h14, 32'h0000_0000);
      `CHK("unmapped", 32'h0000_0000, v)
      bus(1'b1, `ADDR_SUPPLY_CTRL, 32'h0000_0235);
      repeat (3) @(posedge mclk);
      `CHK("target", 4'h5, supply_target_level)
      `CHK("current", 4'h3, supply_charge_current)
      `CHK("charge", 1'b1, supply_charge_enable)
      supply_at_level <= 1'b1;
      repeat (5) @(posedge mclk);
      `CHK("charge", 1'b0, supply_charge_enable)
      bus(1'b0, `ADDR_DEVICE_STATUS, 32'h0000_0000);
      `CHK("ready", 1'b1, v[0])
      supply_at_level <= 1'b0;
      $display("supply test done");
      bus(1'b1, `ADDR_BURST_PULSE, 32'h0000_0002);
      bus(1'b1, `ADDR_DEV_CTRL_THIRD, 32'h0000_0001);
      burst(160, 1);
      `CHK("pulses", 2, pulses)
      `CHK("charge", 1'b0, supply_charge_enable)
      bus(1'b1, `ADDR_SUPPLY_CTRL, 32'h0000_0635);
      repeat (3) @(posedge mclk);
      `CHK("charge", 1'b1, supply_charge_enable)
      burst(160, 1);
      `CHK("pulses", 2, pulses)
      `CHK("charge", 1'b1, supply_charge_enable)
      bus(1'b1, `ADDR_BURST_PULSE, 32'h0000_0000);
      burst(120, 1);
      `CHK("pulses", 1'b1, pulses >= 5 && pulses <= 9)
      $display("first pin mode test done");
      bus(1'b1, `ADDR_BURST_PULSE, 32'h0000_0003);
      bus(1'b1, `ADDR_DEV_CTRL_THIRD, 32'h0000_0000);
      bus(1'b1, `ADDR_FLIGHT_CONFIG, 32'h0000_0001);
      bus(1'b0, `ADDR_DEVICE_STATUS, 32'h0000_0000);
      `CHK("enabled not active", 2'b01, v[3:2])
      burst(160, 0);
      `CHK("pulses", 3, pulses)
      bus(1'b1, `ADDR_FLIGHT_CONFIG, 32'h0000_0001);
      burst(160, 0);
      `CHK("pulses", 0, pulses)
      bus(1'b1, `ADDR_FLIGHT_CONFIG, 32'h0000_0000);
      bus(1'b1, `ADDR_FLIGHT_CONFIG, 32'h0000_0001);
      burst(160, 0);
      `CHK("pulses", 3, pulses)
      bus(1'b1, `ADDR_BURST_PULSE, 32'h0000_0000);
      bus(1'b1, `ADDR_FLIGHT_CONFIG, 32'h0000_0000);
      bus(1'b1, `ADDR_FLIGHT_CONFIG, 32'h0000_0001);
      burst(120, 2);
      `CHK("pulses", 1'b1, pulses >= 5 && pulses <= 9)
      $display("command mode test done");
      two_phase <= 1'b1;
      bus(1'b1, `ADDR_DEV_CTRL_THIRD, 32'h0000_0002);
      bus(1'b1, `ADDR_BURST_PULSE, 32'h0000_0001);
      repeat (2) begin
         burst(120, 0);
         `CHK("pulses", 1'b1, pulses >= 4)
         bus(1'b0, `ADDR_DEVICE_STATUS, 32'h0000_0000);
         `CHK("burst state", 2'b00, v[3:2])
      end
      $display("two pin mode test done");
      // regulation off with listen disable set and recharge clear: a burst must not set listen stop, and charge stays off
      bus(1'b1, `ADDR_SUPPLY_CTRL, 32'h0000_0335);
      burst(120, 0);
      two_phase <= 1'b0;
      bus(1'b0, `ADDR_DEVICE_STATUS, 32'h0000_0000);
      `CHK("status", 5'h00, v[4:0])
      `CHK("charge", 1'b0, supply_charge_enable)
      // mode 3 is not supported and must never burst
      bus(1'b1, `ADDR_DEV_CTRL_THIRD, 32'h0000_0003);
      burst(120, 1);
      `CHK("pulses", 0, pulses)
      $display("regulation off test done");
      close_out();
   end
endmodule
